//--- pcg_map.svh
// Purpose: offsets, field positions, reset values and divide counts
// Assumes: byte addresses on a 32-bit word bus, one register a word
// Notes: definitions only
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH
// ==========================================
// register offsets
`define PCG_OFS_CTRL 8'h00
`define PCG_OFS_BRK 8'h04
`define PCG_OFS_CFG 8'h08
`define PCG_OFS_STAT 8'h0C
`define PCG_OFS_MASK 8'h10
`define PCG_OFS_STATE 8'h14
// ==========================================
// pll_control_reg fields
`define PCG_CTRL_IE 7
`define PCG_CTRL_FLAG 6
`define PCG_CTRL_PON 5
`define PCG_CTRL_BCS 4
`define PCG_CTRL_AUTO 3
// break_flag_control_reg and second_config_reg fields
`define PCG_BRK_BREAK_CLEAR_ENABLE 7
`define PCG_CFG_KEEP 0
// ==========================================
// reset values
`define PCG_RST_CTRL 8'h00
`define PCG_RST_BRK 8'h00
`define PCG_RST_CFG 8'h00
`define PCG_RST_MASK 8'h00
// ==========================================
// event bits and divide counts
`define PCG_NEV 4
`define PCG_EV_LOCK 0
`define PCG_EV_STOP 1
`define PCG_EV_BCSCLR 2
`define PCG_EV_WAKE 3
`define PCG_OSC_DIV 8'h10
`define PCG_VCO_DIV 8'h02
`endif

//--- pcg_pkg.sv
// Purpose: shared types of the clock generation unit
// Assumes: nothing
// Notes: one-hot mode codes
package pcg_pkg;
  typedef enum logic [3:0] {
    PCG_RUN = 4'h1,
    PCG_WAIT = 4'h2,
    PCG_STOP_OFF = 4'h4,
    PCG_STOP_ON = 4'h8
  } pcg_mode_type;
endpackage

//--- pcg_div.sv
// Purpose: enable-pulse divider standing in for a slower clock
// Assumes: i_en low parks the counter at zero
// Notes: one tick every DIV cycles
`timescale 1ns/1ps
module pcg_div #(
  parameter logic [7:0] DIV = 8'h02
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_en,
  // tick
  output logic o_tick
);
  logic [7:0] cnt_r;

  always_ff @(posedge i_clk) begin
    if (i_srst || !i_en) begin
      cnt_r <= 8'h00;
      o_tick <= 1'b0;
    end else if (cnt_r == DIV - 8'h01) begin
      cnt_r <= 8'h00;
      o_tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      o_tick <= 1'b0;
    end
  end
endmodule

//--- pcg_irq.sv
// Purpose: sticky event status, mask and level interrupt
// Assumes: read-clear pulse comes from the bus slave
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_irq (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // events and software access
  input wire logic [`PCG_NEV-1:0] i_event,
  input wire logic i_rd_clr,
  input wire logic i_mask_we,
  input wire logic [`PCG_NEV-1:0] i_wdata,
  // state
  output logic [`PCG_NEV-1:0] o_status,
  output logic [`PCG_NEV-1:0] o_mask,
  output logic o_irq
);
  logic [7:0] rst_mask;
  genvar g;
  assign rst_mask = `PCG_RST_MASK;
  generate
    for (g = 0; g < `PCG_NEV; g = g + 1) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          o_status[g] <= 1'b0;
        end else if (i_event[g]) begin
          o_status[g] <= 1'b1;
        end else if (i_rd_clr) begin
          o_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_mask <= rst_mask[`PCG_NEV-1:0];
    end else if (i_mask_we) begin
      o_mask <= i_wdata;
    end
  end

  assign o_irq = |(o_status & o_mask);
endmodule

//--- pcg_top.sv
// Purpose: clock generation unit control in wait, stop and break
// Assumes: mode requests and lock indicator are synchronous to i_clk
// Notes: oscillator and vco are modelled by enable-pulse dividers
`timescale 1ns/1ps
`include "pcg_map.svh"
module pcg_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // core and system integration unit
  input wire logic i_wait_enter,
  input wire logic i_stop_enter,
  input wire logic i_wake,
  input wire logic i_break_state,
  input wire logic i_pll_lock,
  // clock outputs
  output logic o_osc_en,
  output logic o_pll_en,
  output logic o_osc_clock,
  output logic o_vco_clock,
  output logic o_divided_pll_clock,
  output logic o_clock_unit_main_out,
  // interrupts
  output logic o_pll_interrupt_out,
  output logic o_wake_req,
  output logic o_irq
);
  // ==========================================
  // declarations
  pcg_pkg::pcg_mode_type mode_r;
  pcg_pkg::pcg_mode_type mode_nxt;
  logic ph_wr_r;
  logic ph_rd_r;
  logic [7:0] ph_addr_r;
  logic addr_ph;
  logic ctrl_we;
  logic ctrl_rd;
  logic stat_rd;
  logic [7:0] wd;
  logic ie_r;
  logic flag_r;
  logic pon_r;
  logic bcs_r;
  logic auto_r;
  logic break_clear_enable_r;
  logic keep_r;
  logic lock_d_r;
  logic lock_chg;
  logic flag_clr;
  logic stop_go;
  logic bcs_autoclr;
  logic pll_wake;
  logic osc_tick;
  logic vco_tick;
  logic src_rise;
  logic [`PCG_NEV-1:0] events;
  logic [`PCG_NEV-1:0] stat;
  logic [`PCG_NEV-1:0] mask;
  logic [7:0] rd_mux;
  // reset words, so each register flop but flag_r takes its own bit
  logic [7:0] rst_ctrl;
  logic [7:0] rst_brk;
  logic [7:0] rst_cfg;

  // ==========================================
  // bus slave
  // reads take one wait state because read data is registered in o_hrdata
  assign addr_ph = i_hsel && i_htrans[1] && i_hready;
  assign o_hreadyout = !ph_rd_r;
  assign o_hresp = 1'b0;
  assign wd = i_hwdata[7:0];
  assign ctrl_we = ph_wr_r && (ph_addr_r == `PCG_OFS_CTRL);
  assign ctrl_rd = ph_rd_r && (ph_addr_r == `PCG_OFS_CTRL);
  assign stat_rd = ph_rd_r && (ph_addr_r == `PCG_OFS_STAT);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ph_wr_r <= 1'b0;
      ph_rd_r <= 1'b0;
      ph_addr_r <= 8'h00;
    end else begin
      ph_wr_r <= addr_ph && i_hwrite;
      ph_rd_r <= addr_ph && !i_hwrite;
      if (addr_ph) begin
        ph_addr_r <= i_haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_mux = 8'h00;
    unique case (ph_addr_r)
      `PCG_OFS_CTRL: begin
        rd_mux = {ie_r, flag_r && auto_r, pon_r, bcs_r, auto_r, 3'h0};
      end
      `PCG_OFS_BRK: begin
        rd_mux = {break_clear_enable_r, 7'h00};
      end
      `PCG_OFS_CFG: begin
        rd_mux = {7'h00, keep_r};
      end
      `PCG_OFS_STAT: begin
        rd_mux = {4'h0, stat};
      end
      `PCG_OFS_MASK: begin
        rd_mux = {4'h0, mask};
      end
      `PCG_OFS_STATE: begin
        rd_mux = {i_pll_lock, o_osc_en, o_pll_en, 1'b0, mode_r};
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (ph_rd_r) begin
      o_hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // ==========================================
  // configuration registers
  assign rst_ctrl = `PCG_RST_CTRL;
  assign rst_brk = `PCG_RST_BRK;
  assign rst_cfg = `PCG_RST_CFG;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      break_clear_enable_r <= rst_brk[`PCG_BRK_BREAK_CLEAR_ENABLE];
      keep_r <= rst_cfg[`PCG_CFG_KEEP];
    end else if (ph_wr_r) begin
      if (ph_addr_r == `PCG_OFS_BRK) begin
        break_clear_enable_r <= wd[`PCG_BRK_BREAK_CLEAR_ENABLE];
      end
      if (ph_addr_r == `PCG_OFS_CFG) begin
        keep_r <= wd[`PCG_CFG_KEEP];
      end
    end
  end

  // ==========================================
  // pll control register
  // stop entry wins over a same-cycle select write
  assign stop_go = (mode_r == pcg_pkg::PCG_RUN) && i_stop_enter;
  assign bcs_autoclr = stop_go && bcs_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ie_r <= rst_ctrl[`PCG_CTRL_IE];
      pon_r <= rst_ctrl[`PCG_CTRL_PON];
      auto_r <= rst_ctrl[`PCG_CTRL_AUTO];
    end else if (ctrl_we) begin
      ie_r <= wd[`PCG_CTRL_IE];
      pon_r <= wd[`PCG_CTRL_PON];
      auto_r <= wd[`PCG_CTRL_AUTO];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      bcs_r <= rst_ctrl[`PCG_CTRL_BCS];
    end else if (stop_go) begin
      bcs_r <= 1'b0;
    end else if (ctrl_we) begin
      bcs_r <= wd[`PCG_CTRL_BCS];
    end
  end

  // ==========================================
  // lock-change flag
  assign lock_chg = auto_r && o_pll_en && (i_pll_lock != lock_d_r);
  // a read of the control register clears the flag, not in protected break
  assign flag_clr = ctrl_rd && (!i_break_state || break_clear_enable_r);

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      lock_d_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      lock_d_r <= i_pll_lock;
      if (lock_chg) begin
        flag_r <= 1'b1;
      end else if (flag_clr) begin
        flag_r <= 1'b0;
      end
    end
  end

  // interrupt only with enable and auto; dead with oscillator off in stop
  assign o_pll_interrupt_out = flag_r && ie_r && auto_r
    && (mode_r != pcg_pkg::PCG_STOP_OFF);
  assign pll_wake = (mode_r == pcg_pkg::PCG_WAIT) && o_pll_interrupt_out;
  assign o_wake_req = pll_wake;

  // ==========================================
  // low-power mode sequencer
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      pcg_pkg::PCG_RUN: begin
        if (i_stop_enter) begin
          mode_nxt = keep_r ? pcg_pkg::PCG_STOP_ON : pcg_pkg::PCG_STOP_OFF;
        end else if (i_wait_enter) begin
          mode_nxt = pcg_pkg::PCG_WAIT;
        end
      end
      pcg_pkg::PCG_WAIT: begin
        if (i_wake || pll_wake) begin
          mode_nxt = pcg_pkg::PCG_RUN;
        end
      end
      pcg_pkg::PCG_STOP_OFF, pcg_pkg::PCG_STOP_ON: begin
        if (i_wake) begin
          mode_nxt = pcg_pkg::PCG_RUN;
        end
      end
      default: begin
        mode_nxt = pcg_pkg::PCG_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      mode_r <= pcg_pkg::PCG_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // ==========================================
  // oscillator and pll enables
  // wait is no different from run here
  assign o_osc_en = (mode_r != pcg_pkg::PCG_STOP_OFF);
  assign o_pll_en = pon_r && (mode_r == pcg_pkg::PCG_RUN
    || mode_r == pcg_pkg::PCG_WAIT);

  pcg_div #(
    .DIV(`PCG_OSC_DIV)
  ) u_osc_div (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_en(o_osc_en),
    .o_tick(osc_tick)
  );

  pcg_div #(
    .DIV(`PCG_VCO_DIV)
  ) u_vco_div (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_en(o_pll_en),
    .o_tick(vco_tick)
  );

  // ==========================================
  // clock waveforms
  always_ff @(posedge i_clk) begin
    if (i_srst || !o_osc_en) begin
      o_osc_clock <= 1'b0;
    end else if (osc_tick) begin
      o_osc_clock <= !o_osc_clock;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst || !o_pll_en) begin
      o_vco_clock <= 1'b0;
      o_divided_pll_clock <= 1'b0;
    end else if (vco_tick) begin
      o_vco_clock <= !o_vco_clock;
      if (o_vco_clock) begin
        o_divided_pll_clock <= !o_divided_pll_clock;
      end
    end
  end

  // main output toggles on each rising edge of its source: halved
  // switching source mid-period may shorten one phase; no glitch guard
  assign src_rise = bcs_r ? (vco_tick && o_vco_clock && !o_divided_pll_clock)
    : (osc_tick && !o_osc_clock);

  always_ff @(posedge i_clk) begin
    if (i_srst || mode_r == pcg_pkg::PCG_STOP_OFF) begin
      o_clock_unit_main_out <= 1'b0;
    end else if (src_rise) begin
      o_clock_unit_main_out <= !o_clock_unit_main_out;
    end
  end

  // ==========================================
  // event status and interrupt
  assign events = {pll_wake, bcs_autoclr, stop_go, lock_chg};

  pcg_irq u_irq (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_event(events),
    .i_rd_clr(stat_rd),
    .i_mask_we(ph_wr_r && ph_addr_r == `PCG_OFS_MASK),
    .i_wdata(wd[`PCG_NEV-1:0]),
    .o_status(stat),
    .o_mask(mask),
    .o_irq(o_irq)
  );

  // ==========================================
  // checks
  AST_WAIT_KEEP: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_WAIT && !ctrl_we) |=> $stable(bcs_r) && o_osc_en)
    else $error("wait changed clock unit state");
  AST_WAIT_PLL: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_WAIT && pon_r) |-> o_pll_en)
    else $error("powered pll stopped in wait");
  AST_PLL_WAKE: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_WAIT && o_pll_interrupt_out)
    |-> o_wake_req ##1 mode_r == pcg_pkg::PCG_RUN)
    else $error("pll interrupt did not wake");
  AST_STOP_OFF: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_STOP_OFF) [*2] |-> !o_osc_en && !o_pll_en
    && !o_clock_unit_main_out && !o_vco_clock && !o_divided_pll_clock
    && !o_pll_interrupt_out)
    else $error("output alive in stop with oscillator off");
  AST_STOP_BCS: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_RUN && i_stop_enter) |=> !bcs_r ##1 !bcs_r)
    else $error("select not cleared by stop");
  AST_STOP_KEEP: assert property (@(posedge i_clk) disable iff (i_srst)
    (mode_r == pcg_pkg::PCG_STOP_ON) |-> o_osc_en && !o_pll_en)
    else $error("stop with oscillator kept is wrong");
  AST_BRK_CLR: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_break_state && break_clear_enable_r && ctrl_rd && !lock_chg) |=> !flag_r)
    else $error("flag not cleared in enabled break");
  AST_BRK_PROT: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_break_state && !break_clear_enable_r && flag_r) |=> flag_r)
    else $error("flag lost in protected break");
  AST_LOCK_FLAG: assert property (@(posedge i_clk) disable iff (i_srst)
    lock_chg |=> flag_r && (o_pll_interrupt_out == (ie_r && auto_r
    && mode_r != pcg_pkg::PCG_STOP_OFF)))
    else $error("lock change flag or interrupt gate wrong");
endmodule

//--- pcg_core_model.sv
// Purpose: core and system integration unit in front of the clock unit
// Assumes: requests change just after a rising edge
// Notes: lock indicator can answer late, by a caller-chosen delay
`timescale 1ns/1ps
module pcg_core_model (
  // clock
  input wire logic i_clk,
  // instruction strobes, break and lock
  output logic o_wait_enter,
  output logic o_stop_enter,
  output logic o_wake,
  output logic o_break_state,
  output logic o_pll_lock
);
  // ==========================================
  // drivers
  initial begin
    {o_wait_enter, o_stop_enter, o_wake, o_break_state, o_pll_lock} = '0;
  end
  // one-cycle strobe: 0 wait, 1 stop, 2 wake
  task automatic op(input int k);
    @(posedge i_clk);
    o_wait_enter <= (k == 0);
    o_stop_enter <= (k == 1);
    o_wake <= (k == 2);
    @(posedge i_clk);
    {o_wait_enter, o_stop_enter, o_wake} <= '0;
  endtask
  // slow answer: lock indicator flips on the rising edge dly + 1 cycles later
  task automatic lock_flip(input int dly);
    repeat (dly + 1) @(posedge i_clk);
    o_pll_lock <= !o_pll_lock;
  endtask
  task automatic brk(input logic v);
    @(posedge i_clk);
    o_break_state <= v;
  endtask
endmodule

//--- test_pcg_top.sv
// Purpose: self-checking bench for the clock unit low-power control
// Assumes: one ahb-lite slave, read data checked from a queue
// Notes: clock outputs judged by counting rising edges
`timescale 1ns/1ps
`include "pcg_map.svh"
module test_pcg_top;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [2:0] hsize = 3'b000;
  logic [31:0] hrdata;
  logic hrdy;
  logic hresp;
  logic w_en;
  logic s_en;
  logic wake;
  logic brk;
  logic lock;
  logic osc_en;
  logic pll_en;
  logic osc;
  logic vco;
  logic dpll;
  logic mout;
  logic pint;
  logic wreq;
  logic irq;
  int seen = 0;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic dph_rd = 1'b0;
  logic [15:0] exp_q[$];
  string nm_q[$];
  logic [31:0] rnd = 32'd25673;
  always #2.5 i_clk = ~i_clk;
  pcg_core_model core (.i_clk(i_clk), .o_wait_enter(w_en), .o_stop_enter(s_en),
    .o_wake(wake), .o_break_state(brk), .o_pll_lock(lock));
  pcg_top dut (.i_clk(i_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_wait_enter(w_en), .i_stop_enter(s_en), .i_wake(wake), .i_break_state(brk),
    .i_pll_lock(lock), .o_osc_en(osc_en), .o_pll_en(pll_en), .o_osc_clock(osc),
    .o_vco_clock(vco), .o_divided_pll_clock(dpll), .o_clock_unit_main_out(mout),
    .o_pll_interrupt_out(pint), .o_wake_req(wreq), .o_irq(irq));
  // ==========================================
  // checking
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // read data is judged where it appears, against the oldest note
  always @(posedge i_clk) begin
    logic [15:0] e;
    if (dph_rd && hrdy) begin
      e = exp_q.pop_front();
      chk(nm_q.pop_front(), hrdata & {24'h0, e[15:8]}, {24'h0, e[7:0]});
      chk("hresp", 32'(hresp), 32'h0);
    end
    if (hsel && htrans[1] && hrdy && !hwrite) begin
      dph_rd <= 1'b1;
    end else if (hrdy) begin
      dph_rd <= 1'b0;
    end
  end
  // hang guard, well above the whole sequence
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      test_done();
    end
  end
  // ==========================================
  // bus and helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    haddr <= {24'h0, a};
    do @(negedge i_clk); while (!hrdy);
    @(posedge i_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(negedge i_clk); while (!hrdy);
    @(posedge i_clk);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e);
    exp_q.push_back({m, e});
    nm_q.push_back(n);
    bus(1'b0, a, 8'h00);
  endtask
  // rising edges of one clock output over len cycles: 0 main, 1 vco, 2 osc, 3 divided
  task automatic rises(input string n, input int sel, input int len, input int e);
    int c = 0;
    logic p = 1'b0;
    logic v;
    for (int i = 0; i <= len; i++) begin
      @(negedge i_clk);
      v = (sel == 0) ? mout : (sel == 1) ? vco : (sel == 2) ? osc : dpll;
      if (i > 0 && v === 1'b1 && p === 1'b0) c++;
      p = v;
    end
    chk(n, 32'(c), 32'(e));
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, `PCG_RST_CTRL);
    rd("brk", `PCG_OFS_BRK, 8'h80, `PCG_RST_BRK);
    rd("cfg", `PCG_OFS_CFG, 8'h01, `PCG_RST_CFG);
    rd("state", `PCG_OFS_STATE, 8'hFF, 8'h41);
    bus(1'b1, 8'h18, 8'hFF);
    rd("unmapped", 8'h18, 8'hFF, 8'h00);
    repeat (3) begin
      rnd = xs(rnd);
      bus(1'b1, `PCG_OFS_MASK, rnd[7:0]);
      rd("mask", `PCG_OFS_MASK, 8'h0F, {4'h0, rnd[3:0]});
    end
    bus(1'b1, `PCG_OFS_MASK, 8'h01);
    // flag without enable, then with enable
    bus(1'b1, `PCG_OFS_CTRL, 8'h28);
    core.lock_flip(int'(rnd[1:0]));
    repeat (3) @(negedge i_clk);
    chk("pint", 32'(pint), 32'h0);
    chk("irq", 32'(irq), 32'h1);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'h68);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'h28);
    rd("status", `PCG_OFS_STAT, 8'h0F, 8'h01);
    @(negedge i_clk);
    chk("irq", 32'(irq), 32'h0);
    bus(1'b1, `PCG_OFS_CTRL, 8'hA8);
    core.lock_flip(3);
    repeat (3) @(negedge i_clk);
    chk("pint", 32'(pint), 32'h1);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    // source selection
    bus(1'b1, `PCG_OFS_CTRL, 8'hB8);
    repeat (20) @(posedge i_clk);
    rises("main pll", 0, 128, 8);
    bus(1'b1, `PCG_OFS_CTRL, 8'hA8);
    repeat (70) @(posedge i_clk);
    rises("main osc", 0, 128, 2);
    // wait with pll powered but deselected, woken by lock change
    core.op(0);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h62);
    rises("vco wait", 1, 32, 8);
    rises("divided wait", 3, 32, 4);
    chk("pll en wait", 32'(pll_en), 32'h1);
    core.lock_flip(int'(xs(rnd) & 32'h7));
    // wake request stands for the one cycle before the mode leaves wait
    seen = 0;
    repeat (4) begin
      @(negedge i_clk);
      if (wreq === 1'b1) seen++;
    end
    chk("wake req", 32'(seen), 32'h1);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h61);
    rd("status", `PCG_OFS_STAT, 8'h08, 8'h08);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    bus(1'b1, `PCG_OFS_CTRL, 8'hB8);
    core.op(0);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hB8);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h62);
    core.op(2);
    bus(1'b1, `PCG_OFS_CTRL, 8'h88);
    core.op(0);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h42);
    core.op(2);
    // stop with oscillator off, pll driving the output
    bus(1'b1, `PCG_OFS_CTRL, 8'hB8);
    core.lock_flip(1);
    repeat (3) @(posedge i_clk);
    core.op(1);
    repeat (4) @(posedge i_clk);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h04);
    rises("main stop", 0, 64, 0);
    chk("outs stop", {28'h0, mout, vco, dpll, pint}, 32'h0);
    chk("en stop", {30'h0, osc_en, pll_en}, 32'h0);
    core.op(2);
    rd("ctrl", `PCG_OFS_CTRL, 8'h10, 8'h00);
    rd("status", `PCG_OFS_STAT, 8'h06, 8'h06);
    repeat (70) @(posedge i_clk);
    rises("main after stop", 0, 128, 2);
    // stop with oscillator kept
    bus(1'b1, `PCG_OFS_CFG, 8'h01);
    bus(1'b1, `PCG_OFS_CTRL, 8'hB8);
    core.op(1);
    repeat (4) @(posedge i_clk);
    rd("state", `PCG_OFS_STATE, 8'h6F, 8'h48);
    rises("osc stop", 2, 64, 2);
    rises("vco stop", 1, 32, 0);
    chk("en keep", {30'h0, osc_en, pll_en}, 32'h2);
    core.op(2);
    // break with flag protection, then with clearing allowed
    bus(1'b1, `PCG_OFS_CTRL, 8'hA8);
    core.lock_flip(2);
    repeat (3) @(posedge i_clk);
    core.brk(1'b1);
    rd("ctrl brk", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    bus(1'b1, `PCG_OFS_CTRL, 8'hA8);
    rd("ctrl brk", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    core.brk(1'b0);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hA8);
    bus(1'b1, `PCG_OFS_BRK, 8'h80);
    core.lock_flip(0);
    repeat (3) @(posedge i_clk);
    core.brk(1'b1);
    rd("ctrl brk", `PCG_OFS_CTRL, 8'hF8, 8'hE8);
    rd("ctrl brk", `PCG_OFS_CTRL, 8'hF8, 8'hA8);
    core.brk(1'b0);
    rd("ctrl", `PCG_OFS_CTRL, 8'hF8, 8'hA8);
    test_done();
  end
endmodule
